/* File: logic/ist_params.svh */
// constants of the two-wire slave transmitter: offsets, fields, codes
// assumes inclusion by bare name from the logic folder
`ifndef IST_PARAMS_SVH
`define IST_PARAMS_SVH
// register byte offsets on the apb slave
`define IST_OFS_CTRL   8'h00
`define IST_OFS_STAT   8'h04
`define IST_OFS_DATA   8'h08
`define IST_OFS_ADDR   8'h0C
// bus_control_reg bit positions
`define IST_CTRL_IRQ   7
`define IST_CTRL_ACK   6
`define IST_CTRL_STA   5
`define IST_CTRL_STO   4
`define IST_CTRL_EN    2
// status codes, prescaler bits zero
`define IST_ST_OWN_R   8'hA8
`define IST_ST_ARB_R   8'hB0
`define IST_ST_ACK     8'hB8
`define IST_ST_NACK    8'hC0
`define IST_ST_LASTACK 8'hC8
`define IST_ST_NONE    8'hF8
// reset values
`define IST_DATA_RST   8'hFF
// bit counts within a byte frame
`define IST_BITS       4'h8
`define IST_ACK_BIT    4'h9
// general call address
`define IST_GC_ADDR    7'h00
`endif

/* File: logic/ist_pkg.sv */
// types of the two-wire slave transmitter
// assumes the params header supplies all numeric constants
package ist_pkg;
    // one-hot bus states
    typedef enum logic [6:0] {
        FSM_IDLE     = 7'h01,
        FSM_ADDR     = 7'h02,
        FSM_ADDR_ACK = 7'h04,
        FSM_TX       = 7'h08,
        FSM_TX_ACK   = 7'h10,
        FSM_HOLD     = 7'h20,
        FSM_SKIP     = 7'h40
    } ist_fsm_t;
    // apb request from master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ist_apb_req_t;
    // apb answer to master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ist_apb_rsp_t;
    // raw pin levels
    typedef struct packed {
        logic scl;
        logic sda;
    } ist_pin_in_t;
    // open-drain drives, level always low
    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } ist_pin_out_t;
endpackage

/* File: logic/ist_slave_tx.sv */
// two-wire slave transmitter with apb register access
// assumes open-drain wires resolved outside; sleep level from core domain
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "ist_params.svh"

module ist_slave_tx (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // apb slave
    input  wire ist_pkg::ist_apb_req_t apb_req,
    output      ist_pkg::ist_apb_rsp_t apb_rsp,
    // two-wire pins
    input  wire ist_pkg::ist_pin_in_t  pin_in,
    output      ist_pkg::ist_pin_out_t pin_out,
    // system side
    input  wire logic                  deep_sleep,
    input  wire logic                  arb_lost,
    output      logic                  wake_req,
    output      logic                  start_issue,
    output      logic                  irq_flag
);

    ////////////////////////////////////////////////////////////////////////
    // state

    // all registered state of the block
    typedef struct packed {
        logic               scl_m;      // scl sync stage one
        logic               scl_s;      // scl sync stage two
        logic               scl_d;      // scl previous
        logic               sda_m;      // sda sync stage one
        logic               sda_s;      // sda sync stage two
        logic               sda_d;      // sda previous
        ist_pkg::ist_fsm_t  fsm;        // bus state
        logic [3:0]         bit_cnt;    // bits seen in frame
        logic [7:0]         shift;      // address or data shifter
        logic [6:0]         rx_addr;    // last address heard
        logic               rx_rw;      // last direction bit
        logic               ack_rx;     // master ack of last byte
        logic               last;       // byte sent as final
        logic               sda_low;    // pulling sda
        logic               scl_low;    // stretching scl
        logic               irq;        // irq_flag
        logic               ack_en;     // ack_enable
        logic               sta;        // start_request
        logic               sto;        // stop_request
        logic               en;         // iface_enable
        logic [7:0]         code;       // status code
        logic [7:0]         data;       // bus_data_reg
        logic [7:0]         own;        // slave_address_match
        logic               arb_pend;   // arbitration lost earlier
        logic               busy;       // bus between start and stop
        logic               start_pend; // start wanted when free
        logic               start_go;   // start pulse
        logic               wake;       // wake request
        logic [31:0]        rdata;      // apb read data
        logic               err;        // apb error
    } ist_regs_t;

    ist_regs_t r_reg;   // current state
    ist_regs_t r_next;  // next state

    // edge and condition views
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [7:0] stat_view;
    logic [7:0] heard;
    logic       addr_ok;
    logic       load_state;
    logic       apb_setup;
    logic       apb_wr;

    ////////////////////////////////////////////////////////////////////////
    // combinational views

    // edges on synchronised pins
    assign scl_rise  = r_reg.scl_s & ~r_reg.scl_d;
    assign scl_fall  = ~r_reg.scl_s & r_reg.scl_d;
    assign start_det = r_reg.scl_s & r_reg.scl_d & r_reg.sda_d
                       & ~r_reg.sda_s;
    assign stop_det  = r_reg.scl_s & r_reg.scl_d & ~r_reg.sda_d
                       & r_reg.sda_s;
    assign stat_view = r_reg.irq ? r_reg.code : `IST_ST_NONE;
    // address byte as received
    assign heard     = r_reg.shift;
    // own or enabled general call, gated
    assign addr_ok   = r_reg.ack_en
                       & ((heard[7:1] == r_reg.own[7:1])
                       | ((heard[7:1] == `IST_GC_ADDR) & r_reg.own[0]));
    // states where software loads a byte
    assign load_state = (r_reg.code == `IST_ST_OWN_R)
                        | (r_reg.code == `IST_ST_ARB_R)
                        | (r_reg.code == `IST_ST_ACK);
    // apb phases
    assign apb_setup = apb_req.psel & ~apb_req.penable;
    assign apb_wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;

    ////////////////////////////////////////////////////////////////////////
    // next state

    // registers, apb and bus state machine
    always_comb
    begin
        r_next = r_reg;
        // two-flop synchronisers
        r_next.scl_m    = pin_in.scl;
        r_next.scl_s    = r_reg.scl_m;
        r_next.scl_d    = r_reg.scl_s;
        r_next.sda_m    = pin_in.sda;
        r_next.sda_s    = r_reg.sda_m;
        r_next.sda_d    = r_reg.sda_s;
        r_next.start_go = 1'b0;
        if (arb_lost)
        begin
            r_next.arb_pend = 1'b1;
        end
        // apb setup: prepare read data
        if (apb_setup)
        begin
            r_next.err   = 1'b0;
            r_next.rdata = 32'h0000_0000;
            unique case (apb_req.paddr)
                `IST_OFS_CTRL:
                    r_next.rdata[7:0] = {r_reg.irq, r_reg.ack_en,
                        r_reg.sta, r_reg.sto, 1'b0, r_reg.en, 2'b00};
                `IST_OFS_STAT: r_next.rdata[7:0] = stat_view;
                `IST_OFS_DATA: r_next.rdata[7:0] = r_reg.data;
                `IST_OFS_ADDR: r_next.rdata[7:0] = r_reg.own;
                default:       r_next.err = 1'b1;
            endcase
        end
        // apb access: write takes effect
        if (apb_wr)
        begin
            unique case (apb_req.paddr)
                // enable and ack enable from software
                `IST_OFS_CTRL:
                begin
                    r_next.ack_en = apb_req.pwdata[`IST_CTRL_ACK];
                    r_next.sta    = apb_req.pwdata[`IST_CTRL_STA];
                    r_next.sto    = apb_req.pwdata[`IST_CTRL_STO];
                    r_next.en     = apb_req.pwdata[`IST_CTRL_EN];
                    if (apb_req.pwdata[`IST_CTRL_IRQ])
                    begin
                        r_next.irq = 1'b0;
                    end
                end
                `IST_OFS_DATA: r_next.data = apb_req.pwdata[7:0];
                `IST_OFS_ADDR: r_next.own  = apb_req.pwdata[7:0];
                default: ;
            endcase
        end
        // bus side, after writes so hardware set wins
        if (!r_reg.en)
        begin
            // disabled: release the wires
            r_next.fsm     = ist_pkg::FSM_IDLE;
            r_next.sda_low = 1'b0;
            r_next.scl_low = 1'b0;
            r_next.busy    = 1'b0;
            r_next.wake    = 1'b0;
        end
        else if (stop_det)
        begin
            // stop frees bus, no longer addressed
            r_next.fsm      = ist_pkg::FSM_IDLE;
            r_next.busy     = 1'b0;
            r_next.sda_low  = 1'b0;
            r_next.arb_pend = 1'b0;
        end
        else if (start_det && r_reg.fsm != ist_pkg::FSM_HOLD)
        begin
            // start: listen to address byte
            r_next.fsm     = ist_pkg::FSM_ADDR;
            r_next.busy    = 1'b1;
            r_next.bit_cnt = 4'h0;
            r_next.sda_low = 1'b0;
        end
        else
        begin
            unique case (r_reg.fsm)
                ist_pkg::FSM_IDLE, ist_pkg::FSM_SKIP: ;
                ist_pkg::FSM_ADDR:
                begin
                    // shift address bits on rising scl
                    if (scl_rise)
                    begin
                        r_next.shift   = {r_reg.shift[6:0], r_reg.sda_s};
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && r_reg.bit_cnt == `IST_BITS)
                    begin
                        r_next.rx_addr = heard[7:1];
                        r_next.rx_rw   = heard[0];
                        if (addr_ok && heard[0])
                        begin
                            r_next.sda_low = 1'b1;
                            r_next.fsm     = ist_pkg::FSM_ADDR_ACK;
                        end
                        else
                        begin
                            r_next.fsm = ist_pkg::FSM_SKIP;
                        end
                    end
                end
                ist_pkg::FSM_ADDR_ACK:
                begin
                    if (scl_rise)
                    begin
                        r_next.bit_cnt = `IST_ACK_BIT;
                    end
                    else if (scl_fall && r_reg.bit_cnt == `IST_ACK_BIT)
                    begin
                        r_next.sda_low  = 1'b0;
                        r_next.irq      = 1'b1;
                        r_next.scl_low  = 1'b1;
                        r_next.fsm      = ist_pkg::FSM_HOLD;
                        r_next.arb_pend = 1'b0;
                        r_next.code     = r_reg.arb_pend ? `IST_ST_ARB_R
                                                         : `IST_ST_OWN_R;
                        r_next.wake     = deep_sleep;
                    end
                end
                ist_pkg::FSM_HOLD:
                begin
                    // scl stays low while flag set
                    if (!r_reg.irq)
                    begin
                        r_next.scl_low = 1'b0;
                        r_next.wake    = 1'b0;
                        if (load_state)
                        begin
                            r_next.shift   = r_reg.data;
                            r_next.last    = ~r_reg.ack_en;
                            r_next.bit_cnt = 4'h0;
                            r_next.sda_low = ~r_reg.data[7];
                            r_next.fsm     = ist_pkg::FSM_TX;
                        end
                        else
                        begin
                            r_next.fsm        = ist_pkg::FSM_SKIP;
                            r_next.start_pend = r_reg.sta;
                        end
                    end
                end
                ist_pkg::FSM_TX:
                begin
                    // count bits on rise, change on fall
                    if (scl_rise)
                    begin
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (r_reg.bit_cnt == `IST_BITS)
                        begin
                            r_next.sda_low = 1'b0;
                            r_next.fsm     = ist_pkg::FSM_TX_ACK;
                        end
                        else
                        begin
                            r_next.shift   = {r_reg.shift[6:0], 1'b1};
                            r_next.sda_low = ~r_reg.shift[6];
                        end
                    end
                end
                ist_pkg::FSM_TX_ACK:
                begin
                    // sample master ack on ninth pulse
                    if (scl_rise)
                    begin
                        r_next.ack_rx  = ~r_reg.sda_s;
                        r_next.bit_cnt = `IST_ACK_BIT;
                    end
                    else if (scl_fall && r_reg.bit_cnt == `IST_ACK_BIT)
                    begin
                        r_next.irq     = 1'b1;
                        r_next.scl_low = 1'b1;
                        r_next.fsm     = ist_pkg::FSM_HOLD;
                        if (!r_reg.ack_rx)
                        begin
                            r_next.code = `IST_ST_NACK;
                        end
                        else if (r_reg.last)
                        begin
                            r_next.code = `IST_ST_LASTACK;
                        end
                        else
                        begin
                            r_next.code = `IST_ST_ACK;
                        end
                    end
                end
                default: r_next.fsm = ist_pkg::FSM_IDLE;
            endcase
        end
        // start pulse when bus is free
        if (r_reg.start_pend && !r_reg.busy && r_reg.en)
        begin
            r_next.start_go   = 1'b1;
            r_next.start_pend = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // synchronous reset to constants
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            r_reg       <= '0;
            r_reg.fsm   <= ist_pkg::FSM_IDLE;
            r_reg.data  <= `IST_DATA_RST;
            r_reg.scl_m <= 1'b1;
            r_reg.scl_s <= 1'b1;
            r_reg.scl_d <= 1'b1;
            r_reg.sda_m <= 1'b1;
            r_reg.sda_s <= 1'b1;
            r_reg.sda_d <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // open-drain pins drive low only
    assign pin_out.scl_out = 1'b0;
    assign pin_out.scl_oe  = r_reg.scl_low;
    assign pin_out.sda_out = 1'b0;
    assign pin_out.sda_oe  = r_reg.sda_low;
    // apb answers with no wait
    assign apb_rsp.prdata  = r_reg.rdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = r_reg.err;
    // system side
    assign wake_req    = r_reg.wake;
    assign start_issue = r_reg.start_go;
    assign irq_flag    = r_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_idle_code;
        apb_setup && apb_req.paddr == `IST_OFS_STAT && !r_reg.irq
            |=> apb_rsp.prdata == {24'h00_0000, `IST_ST_NONE};
    endproperty
    a_idle_code: assert property (p_idle_code)
        else $error("status not 0xF8 with flag clear");

    property p_presc_zero;
        apb_setup && apb_req.paddr == `IST_OFS_STAT
            |=> apb_rsp.prdata[2:0] == 3'b000;
    endproperty
    a_presc_zero: assert property (p_presc_zero)
        else $error("prescaler bits of status not zero");

    property p_read_dir;
        $rose(r_reg.irq) && load_state && r_reg.code != `IST_ST_ACK
            |-> r_reg.rx_rw && $past(r_reg.ack_en, 3);
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("transmit entered without read bit");

    property p_addr_match;
        $rose(r_reg.irq) && r_reg.code == `IST_ST_OWN_R
            |-> r_reg.rx_addr == r_reg.own[7:1]
                || (r_reg.rx_addr == `IST_GC_ADDR && r_reg.own[0]);
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("answered an address not enabled");

    property p_hold_scl;
        r_reg.fsm == ist_pkg::FSM_HOLD && r_reg.irq |-> pin_out.scl_oe;
    endproperty
    a_hold_scl: assert property (p_hold_scl)
        else $error("scl released while flag set");

    property p_sda_on_low;
        $changed(pin_out.sda_oe) && $past(r_reg.en)
            && !$past(stop_det) |-> !$past(r_reg.scl_s);
    endproperty
    a_sda_on_low: assert property (p_sda_on_low)
        else $error("sda changed while scl high");

    property p_ack_codes;
        $rose(r_reg.irq) && r_reg.code == `IST_ST_ACK
            |-> r_reg.ack_rx && !r_reg.last;
    endproperty
    a_ack_codes: assert property (p_ack_codes)
        else $error("0xB8 without ack or after last byte");

    property p_nack_code;
        $rose(r_reg.irq) && r_reg.code == `IST_ST_NACK |-> !r_reg.ack_rx;
    endproperty
    a_nack_code: assert property (p_nack_code)
        else $error("0xC0 reported with ack");

    property p_last_ack;
        $rose(r_reg.irq) && r_reg.code == `IST_ST_LASTACK
            |-> r_reg.ack_rx && r_reg.last;
    endproperty
    a_last_ack: assert property (p_last_ack)
        else $error("0xC8 not after acked last byte");

    property p_skip_free;
        r_reg.fsm == ist_pkg::FSM_SKIP |=> !pin_out.sda_oe;
    endproperty
    a_skip_free: assert property (p_skip_free)
        else $error("sda driven while not addressed");

    property p_final_byte;
        $fell(r_reg.irq) && r_reg.fsm == ist_pkg::FSM_HOLD && load_state
            && !r_reg.ack_en |=> r_reg.last && r_reg.fsm == ist_pkg::FSM_TX;
    endproperty
    a_final_byte: assert property (p_final_byte)
        else $error("final byte not marked");

    c_own_read: cover property ($rose(r_reg.irq)
        && r_reg.code == `IST_ST_OWN_R);
    c_byte_ack: cover property ($rose(r_reg.irq)
        && r_reg.code == `IST_ST_ACK);
    c_last_ack: cover property ($rose(r_reg.irq)
        && r_reg.code == `IST_ST_LASTACK);
    c_start_go: cover property (start_issue);

endmodule // ist_slave_tx

/* File: verification/ist_master_rx.sv */
// master receiver model on the two-wire bus
// assumes the bench resolves both wires with a pull-up
`timescale 1ns/100ps
module ist_master_rx (
    // clock and resolved wires
    input  wire logic core_clk,
    input  wire logic scl,
    input  wire logic sda,
    // open-drain pulls, high pulls the wire low
    output logic      scl_low,
    output logic      sda_low
);
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one bit: drive while low, wait out stretching, sample high
    task automatic bit_x(input logic b, output logic r);
        scl_low <= 1'b1;
        tick(2);
        sda_low <= !b;
        tick(5);
        scl_low <= 1'b0;
        tick(1);
        while (!scl) tick(1);
        tick(8);
        r = sda;
    endtask
    // start: sda falls while scl high
    task automatic start;
        logic r;
        bit_x(1'b1, r);
        sda_low <= 1'b1;
        tick(8);
    endtask
    // stop: sda rises while scl high
    task automatic stop;
        logic r;
        bit_x(1'b0, r);
        sda_low <= 1'b0;
        tick(8);
    endtask
    // byte msb first plus ninth bit, then scl held low
    task automatic xfer(input logic [7:0] d, input logic b9,
                        output logic [7:0] q, output logic r9);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], r);
            q = {q[6:0], r};
        end
        bit_x(b9, r9);
        scl_low <= 1'b1;
        tick(8);
    endtask
endmodule // ist_master_rx

/* File: verification/ist_slave_tx_test.sv */
// bench for the two-wire slave transmitter over apb
// assumes the master receiver model and a pulled-up bus
`timescale 1ns/100ps
`include "ist_params.svh"
module ist_slave_tx_test;
    logic core_clk, sys_rst, deep_sleep, arb_lost, m_scl, m_sda;
    logic                  wake_req, start_issue, irq_flag, r;
    ist_pkg::ist_apb_req_t req;
    ist_pkg::ist_apb_rsp_t rsp;
    ist_pkg::ist_pin_in_t  pin_in;
    ist_pkg::ist_pin_out_t pin_out;
    int fail_count = 0, n_checks = 0, cyc = 0, starts = 0;
    logic [31:0] q;
    logic [7:0]  b;
    logic [7:0]  bad [3] = '{8'h54, 8'h57, 8'h01};
    // wired-and of both parties
    assign pin_in.scl = !m_scl & (pin_out.scl_oe ? pin_out.scl_out : 1'b1);
    assign pin_in.sda = !m_sda & (pin_out.sda_oe ? pin_out.sda_out : 1'b1);
    ist_slave_tx dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .apb_req(req), .apb_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out),
        .deep_sleep(deep_sleep), .arb_lost(arb_lost), .wake_req(wake_req),
        .start_issue(start_issue), .irq_flag(irq_flag));
    ist_master_rx mst_u (.core_clk(core_clk), .scl(pin_in.scl),
        .sda(pin_in.sda), .scl_low(m_scl), .sda_low(m_sda));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // cycle ceiling and start pulse count
    always @(posedge core_clk)
    begin
        cyc++;
        if (start_issue === 1'b1) starts++;
        if (cyc == 20000)
        begin
            fail_count++;
            complete_run;
        end
    end
    task automatic complete_run;
        if (fail_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask
    // apb transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        req <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do @(posedge core_clk); while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        req <= '0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // start, address byte, ninth level compared
    task automatic adr(input logic [7:0] a, input logic e);
        mst_u.start;
        mst_u.xfer(a, 1'b1, b, r);
        chk(r, e);
    endtask
    initial
    begin
        sys_rst = 1'b1;
        deep_sleep = 1'b0;
        arb_lost = 1'b0;
        req = '0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        mst_u.tick(3);
        rdc(`IST_OFS_STAT, 32'hF8);
        chk(rsp.pslverr, 1'b0);
        rdc(8'h10, 32'h0);
        chk(rsp.pslverr, 1'b1);
        apb(1'b1, `IST_OFS_ADDR, 32'h54);
        rdc(`IST_OFS_ADDR, 32'h54);
        apb(1'b1, `IST_OFS_CTRL, 32'h44);
        foreach (bad[i])
        begin
            adr(bad[i], 1'b1);
            mst_u.stop;
        end
        adr(8'h55, 1'b0);
        chk(irq_flag, 1'b1);
        rdc(`IST_OFS_STAT, 32'hA8);
        apb(1'b1, `IST_OFS_DATA, 32'hA5);
        apb(1'b1, `IST_OFS_CTRL, 32'hC4);
        mst_u.xfer(8'hFF, 1'b0, b, r);
        chk(b, 8'hA5);
        rdc(`IST_OFS_STAT, 32'hB8);
        apb(1'b1, `IST_OFS_DATA, 32'h3C);
        apb(1'b1, `IST_OFS_CTRL, 32'h84);
        mst_u.xfer(8'hFF, 1'b0, b, r);
        chk(b, 8'h3C);
        rdc(`IST_OFS_STAT, 32'hC8);
        apb(1'b1, `IST_OFS_CTRL, 32'h84);
        mst_u.xfer(8'hFF, 1'b0, b, r);
        chk(b, 8'hFF);
        rdc(`IST_OFS_STAT, 32'hF8);
        mst_u.stop;
        adr(8'h55, 1'b1);
        mst_u.stop;
        apb(1'b1, `IST_OFS_CTRL, 32'h44);
        arb_lost <= 1'b1;
        @(posedge core_clk);
        arb_lost <= 1'b0;
        adr(8'h55, 1'b0);
        rdc(`IST_OFS_STAT, 32'hB0);
        apb(1'b1, `IST_OFS_DATA, 32'h0F);
        apb(1'b1, `IST_OFS_CTRL, 32'hC4);
        mst_u.xfer(8'hFF, 1'b1, b, r);
        rdc(`IST_OFS_STAT, 32'hC0);
        apb(1'b1, `IST_OFS_CTRL, 32'hE4);
        chk(starts, 0);
        mst_u.stop;
        mst_u.tick(4);
        chk(starts, 1);
        apb(1'b1, `IST_OFS_ADDR, 32'h55);
        apb(1'b1, `IST_OFS_CTRL, 32'h44);
        deep_sleep <= 1'b1;
        adr(8'h01, 1'b0);
        chk(wake_req, 1'b1);
        chk(pin_out.scl_oe, 1'b1);
        deep_sleep <= 1'b0;
        apb(1'b1, `IST_OFS_CTRL, 32'h84);
        mst_u.tick(2);
        chk(pin_out.scl_oe, 1'b0);
        chk(wake_req, 1'b0);
        mst_u.xfer(8'hFF, 1'b1, b, r);
        chk(b, 8'h0F);
        rdc(`IST_OFS_STAT, 32'hC0);
        apb(1'b1, `IST_OFS_CTRL, 32'h84);
        mst_u.stop;
        complete_run;
    end
endmodule // ist_slave_tx_test
